// [design/gp_timer_defines.vh]
// Purpose: shared constants for the general timer half
// Assumes: 100 MHz system clock
// Notes: definitions only
`ifndef GP_TIMER_DEFINES_VH
`define GP_TIMER_DEFINES_VH
`define CFG_32BIT 3'h0
`define CFG_32RTC 3'h1
`define CFG_16BIT 3'h4
`define MODE_ONESHOT 2'h1
`define MODE_PERIODIC 2'h2
`define MODE_CAPTURE 2'h3
`define EVT_RISE 2'h0
`define EVT_FALL 2'h1
`define EVT_BOTH 2'h3
`define LOAD_RESET 16'hffff
`define MATCH_RESET 16'hffff
`define COUNT_ZERO 16'h0000
`define PRESCALE_ZERO 8'h00
`define RTC_DIV_LAST 15'h7fff
`define RTC_START 32'h00000001
`define RTC_ZERO 32'h00000000
`endif

// [design/pin_edge_detect.v]
// Purpose: synchronise the capture/compare pin and flag its edges
// Assumes: pin is asynchronous to clk
// Notes: first stage is read only by the second
`timescale 1ns/100ps
`default_nettype none
module pin_edge_detect (
    input wire clk,
    input wire arst_n,
    input wire pin_in,
    output wire rise,
    output wire fall,
    output wire level
);
    reg sync_a;
    reg sync_b;
    reg last;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            last <= 1'b0;
        end else begin
            sync_a <= pin_in;
            sync_b <= sync_a;
            last <= sync_b;
        end
    end
    assign rise = sync_b & ~last;
    assign fall = ~sync_b & last;
    assign level = sync_b;
endmodule // pin_edge_detect
`default_nettype wire

// [design/rtc_second_tick.v]
// Purpose: divide the sampled 32.768 kHz clock-mode input to a 1 Hz enable
// Assumes: rise is a one-cycle pulse per input period
// Notes: the divider restarts while disabled
`timescale 1ns/100ps
`default_nettype none
`include "gp_timer_defines.vh"
module rtc_second_tick (
    input wire clk,
    input wire arst_n,
    input wire run,
    input wire rise,
    output reg tick
);
    reg [14:0] div;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div <= 15'h0000;
            tick <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (!run) begin
                div <= 15'h0000;
            end else if (rise) begin
                if (div == `RTC_DIV_LAST) begin
                    div <= 15'h0000;
                    tick <= 1'b1;
                end else begin
                    div <= div + 15'h0001;
                end
            end
        end
    end
endmodule // rtc_second_tick
`default_nettype wire

// [design/general_timer_capture_pwm.v]
// Purpose: one general timer half with edge count, edge time, PWM, one-shot/periodic
//          and a 32-bit mode sequence including clock mode
// Assumes: control bits are plain ports, stable during configuration; clear strobes one cycle
// Notes: run enable is held inside; software sets it by a start pulse, clears by a stop pulse
`timescale 1ns/100ps
`default_nettype none
`include "gp_timer_defines.vh"
// Operation
// R1: the source holds each new level two clocks; edge rate limit is a quarter clock.
// R2: prescaler is bypassed in edge count, edge time and PWM modes.
// R3: capture select 0 gives an edge-counting down-counter on the selected edges.
// R4: software sets match so load minus match equals the wanted edge count.
// R5: each selected edge decrements; equal to match sets count-match raw and masked flags.
// R6: after match reload from load, drop run enable, ignore edges until restarted.
// R7: capture select 1 gives a free-running down-counter from load, 0xFFFF after reset.
// R8: each selected edge copies the count to the value register and sets capture flags.
// R9: edge time keeps counting while enabled and reloads from load at zero.
// R10: PWM mode is alternate select 1, capture select 0, mode field 2.
// R11: PWM counts to zero, reloads next cycle, repeats until run enable clears.
// R12: PWM mode sets no status flags.
// R13: PWM output goes active at load value and inactive at match value.
// R14: the invert bit drives the complement of the PWM waveform.
// R15: software enables the timer clock through clock gating before use.
// R16: 32-bit sequence: stop, config 0, mode 1 or 2, load, unmask, enable.
// R17: writing one to a clear bit clears the raw and the masked flag.
// R18: a one-shot stops after timeout; a periodic one keeps counting.
// R19: clock-mode sequence: stop, config 1, match, stall override, unmask, enable.
// R20: clock mode needs a 32.768 kHz clock on the capture/compare input.
// R21: clock-mode match sets its raw flag and counting goes on until disabled.
// R22: 16-bit sequence: stop, config 4, mode, prescale, load, unmask, enable.
// R23: the pin is synchronised and edges found from successive samples.
module general_timer_capture_pwm (
    input wire clk,
    input wire arst_n,
    input wire [2:0] global_config,
    input wire [1:0] timer_mode_field,
    input wire capture_mode_select,
    input wire alternate_mode_select,
    input wire [1:0] edge_event_select,
    input wire pwm_output_invert,
    input wire debug_halt,
    input wire stall_enable,
    input wire clock_mode_stall_override,
    input wire timer_run_start,
    input wire timer_run_stop,
    input wire load_write,
    input wire [31:0] load_data,
    input wire match_write,
    input wire [31:0] match_data,
    input wire [7:0] prescale_value,
    input wire timeout_mask,
    input wire count_match_mask,
    input wire edge_capture_mask,
    input wire clock_match_mask,
    input wire half_timeout_clear,
    input wire count_match_clear,
    input wire edge_capture_clear,
    input wire clock_match_clear,
    input wire capture_compare_pin_in,
    output wire capture_compare_pin_out,
    output wire capture_compare_pin_oe,
    output reg timer_run_enable,
    output reg [31:0] current_count_value,
    output reg half_timeout_raw_flag,
    output wire half_timeout_masked_flag,
    output reg count_match_raw_flag,
    output wire count_match_masked_flag,
    output reg edge_capture_raw_flag,
    output wire edge_capture_masked_flag,
    output reg clock_match_raw_flag,
    output wire clock_match_masked_flag
);
    reg [31:0] counter;
    reg [31:0] interval_load_value;
    reg [31:0] match_value;
    reg [7:0] prescale_count;
    reg pwm_level;
    reg rtc_started;
    wire pin_rise;
    wire pin_fall;
    wire rtc_tick;

    function event_hit;
        input [1:0] sel;
        input r;
        input f;
        begin
            case (sel)
                `EVT_RISE: event_hit = r;
                `EVT_FALL: event_hit = f;
                `EVT_BOTH: event_hit = r | f;
                default: event_hit = 1'b0;
            endcase
        end
    endfunction

    // 16-bit modes see only the low half of load, match and counter words
    function [31:0] mode_word;
        input narrow;
        input [31:0] value;
        begin
            if (narrow) begin
                mode_word = {16'h0000, value[15:0]};
            end else begin
                mode_word = value;
            end
        end
    endfunction

    // down-count step shared by the free-running modes
    function [31:0] count_step;
        input zero;
        input [31:0] value;
        input [31:0] reload;
        begin
            if (zero) begin
                count_step = reload;
            end else begin
                count_step = value - 32'h00000001;
            end
        end
    endfunction

    pin_edge_detect u_edge ( // R23
        .clk(clk),
        .arst_n(arst_n),
        .pin_in(capture_compare_pin_in),
        .rise(pin_rise),
        .fall(pin_fall),
        .level()
    );

    wire is_16 = (global_config == `CFG_16BIT);
    wire is_32 = (global_config == `CFG_32BIT);
    wire is_rtc = (global_config == `CFG_32RTC);
    wire mode_pwm = is_16 & alternate_mode_select & ~capture_mode_select
        & (timer_mode_field == `MODE_PERIODIC); // R10
    wire mode_capture = is_16 & ~alternate_mode_select & (timer_mode_field == `MODE_CAPTURE);
    wire mode_count = mode_capture & ~capture_mode_select; // R3
    wire mode_time = mode_capture & capture_mode_select; // R7
    wire mode_timer = (is_16 | is_32) & ~alternate_mode_select
        & ((timer_mode_field == `MODE_ONESHOT) | (timer_mode_field == `MODE_PERIODIC));
    wire sel_edge = event_hit(edge_event_select, pin_rise, pin_fall);
    wire stalled = stall_enable & debug_halt & ~(is_rtc & clock_mode_stall_override);
    wire [31:0] load_now = mode_word(is_16, interval_load_value);
    wire [31:0] match_now = mode_word(is_16, match_value);
    wire at_zero = is_16 ? (counter[15:0] == `COUNT_ZERO) : (counter == `RTC_ZERO);
    // prescaler only in plain 16-bit timer modes
    wire use_prescale = is_16 & mode_timer; // R2
    wire pre_tick = ~use_prescale | (prescale_count == `PRESCALE_ZERO);

    rtc_second_tick u_rtc (
        .clk(clk),
        .arst_n(arst_n),
        .run(timer_run_enable & is_rtc),
        .rise(pin_rise), // R20
        .tick(rtc_tick)
    );

    reg set_timeout;
    reg set_cmatch;
    reg set_capture;
    reg set_rtc;
    reg stop_self;
    reg [31:0] next_counter;
    reg do_capture;
    always @* begin
        set_timeout = 1'b0;
        set_cmatch = 1'b0;
        set_capture = 1'b0;
        set_rtc = 1'b0;
        stop_self = 1'b0;
        do_capture = 1'b0;
        next_counter = counter;
        if (load_write && !timer_run_enable) begin
            next_counter = mode_word(is_16, load_data);
        end else if (timer_run_enable) begin
            if (mode_count) begin
                if (sel_edge) begin
                    if (counter[15:0] - 16'h0001 == match_now[15:0]) begin // R5
                        set_cmatch = 1'b1;
                        stop_self = 1'b1; // R6
                        next_counter = load_now; // R6
                    end else begin
                        next_counter = counter - 32'h00000001; // R5
                    end
                end
            end else if (mode_time) begin
                if (sel_edge) begin
                    do_capture = 1'b1; // R8
                    set_capture = 1'b1; // R8
                end
                next_counter = count_step(at_zero, counter, load_now); // R9
            end else if (mode_pwm) begin
                next_counter = count_step(at_zero, counter, load_now); // R11
            end else if (is_rtc) begin
                if (rtc_tick && !stalled) begin
                    if (counter == match_now) begin
                        set_rtc = 1'b1; // R21
                        next_counter = `RTC_ZERO;
                    end else begin
                        next_counter = counter + 32'h00000001;
                    end
                end
            end else if (mode_timer && !stalled && pre_tick) begin
                if (at_zero) begin
                    next_counter = load_now;
                    set_timeout = 1'b1;
                    stop_self = (timer_mode_field == `MODE_ONESHOT); // R18
                end else begin
                    next_counter = counter - 32'h00000001;
                end
            end
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            interval_load_value <= {16'h0000, `LOAD_RESET};
            match_value <= {16'h0000, `MATCH_RESET};
            counter <= {16'h0000, `LOAD_RESET}; // R7
            current_count_value <= {16'h0000, `LOAD_RESET};
            prescale_count <= `PRESCALE_ZERO;
            timer_run_enable <= 1'b0;
            rtc_started <= 1'b0;
            pwm_level <= 1'b0;
            half_timeout_raw_flag <= 1'b0;
            count_match_raw_flag <= 1'b0;
            edge_capture_raw_flag <= 1'b0;
            clock_match_raw_flag <= 1'b0;
        end else begin
            if (load_write) begin
                interval_load_value <= load_data;
            end
            if (match_write) begin
                match_value <= match_data;
            end
            if (timer_run_start && is_rtc && !rtc_started) begin
                counter <= `RTC_START;
                rtc_started <= 1'b1;
            end else begin
                counter <= next_counter;
            end
            if (!is_rtc) begin
                rtc_started <= 1'b0;
            end
            if (!timer_run_enable || !use_prescale || pre_tick) begin
                prescale_count <= prescale_value; // R2
            end else if (!stalled) begin
                prescale_count <= prescale_count - 8'h01;
            end
            if (timer_run_start) begin
                timer_run_enable <= 1'b1;
            end else if (timer_run_stop || stop_self) begin
                timer_run_enable <= 1'b0; // R6
            end
            if (do_capture) begin
                current_count_value <= counter; // R8
            end else if (!mode_time) begin
                current_count_value <= counter;
            end
            if (!mode_pwm || !timer_run_enable) begin
                pwm_level <= 1'b0;
            end else if (counter == load_now) begin
                pwm_level <= 1'b1; // R13
            end else if (counter == match_now) begin
                pwm_level <= 1'b0; // R13
            end
            // set beats a clear in the same cycle; PWM mode never raises any flag
            if (set_timeout && !mode_pwm) begin
                half_timeout_raw_flag <= 1'b1; // R12
            end else if (half_timeout_clear) begin
                half_timeout_raw_flag <= 1'b0; // R17
            end
            if (set_cmatch) begin
                count_match_raw_flag <= 1'b1;
            end else if (count_match_clear) begin
                count_match_raw_flag <= 1'b0; // R17
            end
            if (set_capture) begin
                edge_capture_raw_flag <= 1'b1;
            end else if (edge_capture_clear) begin
                edge_capture_raw_flag <= 1'b0; // R17
            end
            if (set_rtc) begin
                clock_match_raw_flag <= 1'b1;
            end else if (clock_match_clear) begin
                clock_match_raw_flag <= 1'b0; // R17
            end
        end
    end

    assign half_timeout_masked_flag = half_timeout_raw_flag & timeout_mask;
    assign count_match_masked_flag = count_match_raw_flag & count_match_mask; // R5
    assign edge_capture_masked_flag = edge_capture_raw_flag & edge_capture_mask; // R8
    assign clock_match_masked_flag = clock_match_raw_flag & clock_match_mask;
    assign capture_compare_pin_out = pwm_level ^ pwm_output_invert; // R14
    assign capture_compare_pin_oe = mode_pwm;
endmodule // general_timer_capture_pwm
`default_nettype wire

// [bench/general_timer_properties.sv]
// Purpose: port-level checks on the timer half
// Assumes: mode inputs stay steady while the timer runs
// Notes: bound into every timer half instance
`timescale 1ns/100ps
`default_nettype none
module general_timer_properties (
    input wire clk,
    input wire arst_n,
    input wire [2:0] global_config,
    input wire [1:0] timer_mode_field,
    input wire capture_mode_select,
    input wire alternate_mode_select,
    input wire pwm_output_invert,
    input wire timer_run_start,
    input wire timer_run_stop,
    input wire load_write,
    input wire [31:0] load_data,
    input wire [31:0] match_data,
    input wire count_match_mask,
    input wire count_match_clear,
    input wire half_timeout_clear,
    input wire capture_compare_pin_out,
    input wire capture_compare_pin_oe,
    input wire timer_run_enable,
    input wire [31:0] current_count_value,
    input wire half_timeout_raw_flag,
    input wire count_match_raw_flag,
    input wire count_match_masked_flag,
    input wire edge_capture_raw_flag
);
    wire pwm = global_config == 3'h4 && alternate_mode_select && !capture_mode_select && timer_mode_field == 2'h2;
    wire cnt = global_config == 3'h4 && timer_mode_field == 2'h3 && !capture_mode_select;
    wire [15:0] cnt16 = current_count_value[15:0];
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    AST_PWM_SET: assert property (pwm && timer_run_enable && cnt16 == load_data[15:0]
        |=> capture_compare_pin_out == !pwm_output_invert) else $error("pwm output not active at load");
    AST_PWM_CLEAR: assert property (pwm && timer_run_enable && cnt16 == match_data[15:0]
        |=> capture_compare_pin_out == pwm_output_invert) else $error("pwm output not inactive at match");
    AST_PWM_OE: assert property (capture_compare_pin_oe == pwm)
        else $error("pin drive does not follow pwm mode");
    AST_PWM_QUIET: assert property (pwm && timer_run_enable |=> !$rose(count_match_raw_flag)
        && !$rose(edge_capture_raw_flag) && !$rose(half_timeout_raw_flag)) else $error("flag raised in pwm mode");
    AST_COUNT_MASKED: assert property (count_match_masked_flag == (count_match_raw_flag && count_match_mask))
        else $error("masked count flag wrong");
    AST_MATCH_STOP: assert property (cnt && $rose(count_match_raw_flag) |-> ##[0:1] !timer_run_enable)
        else $error("run enable kept after match");
    AST_MATCH_RELOAD: assert property (cnt && $rose(count_match_raw_flag)
        |-> ##[0:1] cnt16 == load_data[15:0]) else $error("no reload after match");
    AST_EDGE_IDLE: assert property (cnt && !timer_run_enable && !timer_run_start && !load_write
        |-> ##2 $stable(current_count_value)) else $error("count moved while stopped");
    AST_CLEAR_MATCH: assert property (count_match_clear && !timer_run_enable |=> !count_match_raw_flag)
        else $error("count flag not cleared");
    AST_CLEAR_TIMEOUT: assert property (half_timeout_clear && !timer_run_enable |=> !half_timeout_raw_flag)
        else $error("timeout flag not cleared");
    AST_ONESHOT_STOP: assert property (timer_mode_field == 2'h1 && $rose(half_timeout_raw_flag)
        |-> ##[0:1] !timer_run_enable) else $error("one-shot kept running");
    AST_PERIODIC_RUN: assert property (timer_mode_field == 2'h2 && !alternate_mode_select
        && $rose(half_timeout_raw_flag) && !$past(timer_run_stop) |-> timer_run_enable)
        else $error("periodic timer stopped");
    cover property (cnt && $rose(count_match_raw_flag));
    cover property ($rose(edge_capture_raw_flag));
    cover property ($rose(half_timeout_raw_flag));
    cover property (pwm && $rose(capture_compare_pin_out));
endmodule // general_timer_properties
bind general_timer_capture_pwm general_timer_properties chk (.*);
`default_nettype wire

// [bench/pin_edge_source.sv]
// Purpose: external source toggling the capture/compare pin
// Assumes: clocked from the bench clock
// Notes: each level stands HOLD clocks; HOLD below 2 would break the edge rate limit
`timescale 1ns/100ps
`default_nettype none
module pin_edge_source #(parameter int HOLD = 4) (
    input wire logic clk,
    input wire logic go,
    input wire logic [7:0] edges,
    output logic pin,
    output logic busy
);
    int left = 0;
    int gap = 0;
    initial pin = 1'b0;
    initial busy = 1'b0;
    always @(posedge clk) begin
        if (busy) begin
            if (gap == HOLD - 1) begin
                gap <= 0;
                pin <= !pin;
                left <= left - 1;
                busy <= left > 1;
            end else begin
                gap <= gap + 1;
            end
        end else if (go) begin
            left <= edges;
            gap <= 0;
            busy <= edges != 8'h00;
        end
    end
endmodule // pin_edge_source
`default_nettype wire

// [bench/general_timer_capture_pwm_bench.sv]
// Purpose: self-checking bench for the timer half
// Assumes: inputs change on the falling clock edge
// Notes: prescale left nonzero so a mode that wrongly uses it shows in the timing
`timescale 1ns/100ps
`default_nettype none
module general_timer_capture_pwm_bench;
    logic clk = 1'b0, arst_n = 1'b0, go = 1'b0, src_busy;
    logic [2:0] global_config = 3'h4;
    logic [1:0] timer_mode_field = 2'h3, edge_event_select = 2'h3;
    logic capture_mode_select = 1'b0, alternate_mode_select = 1'b0, pwm_output_invert = 1'b0;
    logic debug_halt = 1'b0, stall_enable = 1'b0, clock_mode_stall_override = 1'b0;
    logic timer_run_start = 1'b0, timer_run_stop = 1'b0, load_write = 1'b0, match_write = 1'b0;
    logic [31:0] load_data = 32'h0000ffff, match_data = 32'h0000ffff;
    logic [7:0] prescale_value = 8'h03, edges = 8'h00;
    logic timeout_mask = 1'b1, count_match_mask = 1'b1, edge_capture_mask = 1'b1, clock_match_mask = 1'b0;
    logic half_timeout_clear = 1'b0, count_match_clear = 1'b0, edge_capture_clear = 1'b0, clock_match_clear = 1'b0;
    logic capture_compare_pin_in;
    wire capture_compare_pin_out, capture_compare_pin_oe, timer_run_enable;
    wire [31:0] current_count_value;
    wire half_timeout_raw_flag, half_timeout_masked_flag, count_match_raw_flag, count_match_masked_flag;
    wire edge_capture_raw_flag, edge_capture_masked_flag, clock_match_raw_flag, clock_match_masked_flag;
    int miscompares = 0, checks_done = 0;
    general_timer_capture_pwm uut (.*);
    pin_edge_source src (.clk(clk), .go(go), .edges(edges), .pin(capture_compare_pin_in), .busy(src_busy));
    always #5 clk = !clk;
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
        @(negedge clk);
    endtask
    // stop first so mode and values only change while idle
    task automatic setup(input logic [1:0] mode, input logic cms, input logic ams, input logic [31:0] ld,
                         input logic [31:0] mt);
        pulse(timer_run_stop);
        timer_mode_field = mode;
        capture_mode_select = cms;
        alternate_mode_select = ams;
        load_data = ld;
        match_data = mt;
        load_write = 1'b1;
        match_write = 1'b1;
        @(negedge clk);
        load_write = 1'b0;
        match_write = 1'b0;
        @(negedge clk);
    endtask
    task automatic send_edges(input logic [7:0] n);
        edges = n;
        go = 1'b1;
        tick(2);
        go = 1'b0;
        for (int i = 0; i < 400 && src_busy; i++) @(negedge clk);
        tick(6);
    endtask
    initial begin
        logic [31:0] cap;
        int r0, r1;
        logic p;
        tick(12);
        arst_n = 1'b1;
        tick(1);
        cmp(current_count_value, 32'h0000ffff);
        cmp({timer_run_enable, count_match_raw_flag, edge_capture_raw_flag, half_timeout_raw_flag}, 32'h0);
        cmp({clock_match_raw_flag, clock_match_masked_flag, capture_compare_pin_out, capture_compare_pin_oe}, 32'h0);
        $display("test reset done");
        for (int k = 0; k < 4; k++) begin
            setup(2'h3, 1'b0, 1'b0, 32'h0000000a, 32'h00000006);
            edge_event_select = (k == 0) ? 2'h3 : 2'(k - 1);
            pulse(timer_run_start);
            send_edges(8'd6);
            cmp({count_match_raw_flag, count_match_masked_flag, timer_run_enable}, k == 0 ? 32'h6 : 32'h1);
            cmp(current_count_value, (k == 0 || k == 3) ? 32'h0000000a : 32'h00000007);
            pulse(timer_run_stop);
            pulse(count_match_clear);
            cmp({count_match_raw_flag, count_match_masked_flag}, 32'h0);
        end
        $display("test edge count done");
        setup(2'h3, 1'b1, 1'b0, 32'h00000100, 32'h00000000);
        edge_event_select = 2'h0;
        pulse(timer_run_start);
        tick(20);
        send_edges(8'd2);
        cap = current_count_value;
        cmp({edge_capture_raw_flag, edge_capture_masked_flag, timer_run_enable, cap <= 32'h100}, 32'hf);
        tick(10);
        cmp(current_count_value, cap);
        pulse(edge_capture_clear);
        tick(300);
        send_edges(8'd2);
        cmp({edge_capture_raw_flag, current_count_value <= 32'h100, current_count_value != cap}, 32'h7);
        pulse(timer_run_stop);
        pulse(edge_capture_clear);
        cmp({edge_capture_raw_flag, edge_capture_masked_flag}, 32'h0);
        $display("test edge time done");
        for (int k = 0; k < 2; k++) begin
            setup(2'h2, 1'b0, 1'b1, 32'h00000010, 32'h00000008);
            pwm_output_invert = k[0];
            pulse(timer_run_start);
            r0 = -1;
            r1 = -1;
            for (int i = 0; i < 200 && r1 < 0; i++) begin
                p = capture_compare_pin_out;
                @(negedge clk);
                if (capture_compare_pin_out && !p) begin
                    if (r0 < 0) r0 = i;
                    else r1 = i;
                end
            end
            cmp(32'(r1 - r0), 32'h00000011);
            cmp({capture_compare_pin_oe, timer_run_enable, count_match_raw_flag, edge_capture_raw_flag}, 32'hc);
        end
        $display("test pwm done");
        for (int k = 1; k < 3; k++) begin
            pulse(timer_run_stop);
            global_config = (k == 1) ? 3'h0 : 3'h4;
            setup(2'(k), 1'b0, 1'b0, 32'h00000020, 32'h0000ffff);
            pulse(timer_run_start);
            for (int i = 0; i < 400 && !half_timeout_raw_flag; i++) @(negedge clk);
            tick(2);
            cmp({half_timeout_raw_flag, half_timeout_masked_flag, timer_run_enable}, k == 1 ? 32'h6 : 32'h7);
            debug_halt = 1'b1;
            stall_enable = 1'b1;
            tick(1);
            cap = current_count_value;
            tick(5);
            cmp(current_count_value, cap);
            debug_halt = 1'b0;
            stall_enable = 1'b0;
            pulse(timer_run_stop);
            pulse(half_timeout_clear);
            cmp({half_timeout_raw_flag, half_timeout_masked_flag}, 32'h0);
        end
        $display("test one-shot and periodic done");
        global_config = 3'h1;
        setup(2'h0, 1'b0, 1'b0, 32'h00000000, 32'h00000003);
        clock_mode_stall_override = 1'b1;
        clock_match_mask = 1'b1;
        pulse(timer_run_start);
        // a full second takes 32768 input periods, beyond the run budget: only the start state is checked
        send_edges(8'h04);
        cmp(current_count_value, 32'h00000001);
        cmp({clock_match_raw_flag, clock_match_masked_flag, timer_run_enable}, 32'h1);
        pulse(timer_run_stop);
        $display("test clock mode done");
        stop_test();
    end
    // the tests need about 850 cycles
    initial begin
        #200000;
        miscompares++;
        stop_test();
    end
endmodule // general_timer_capture_pwm_bench
`default_nettype wire
